//--- tlk_pkg.sv
package tlk_pkg;
   // lane count and payload geometry
   localparam int LANES = 2;
   localparam int LANE_W = 32;
   localparam int OCT_W = 8;
   localparam int PAY_W = LANES * LANE_W;
   // reconfiguration port: byte-wide data, shared strobes
   localparam int RCFG_DW = 8;
   localparam int RCFG_AW = 11;
   // buffer geometry
   localparam int FIFO_DEPTH = 32;
   // cycles the reset controller waits after analog ready before releasing
   localparam int RST_HOLD_CYC = 4;
   // link phases
   typedef enum logic [1:0] {TLK_DOWN, TLK_SYNC, TLK_USER} tlk_phase_t;
   // host-visible register addresses (controller side)
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h1;
   localparam logic [3:0] REG_RCFG_ADDR = 4'h2;
   localparam logic [3:0] REG_RCFG_DATA = 4'h3;
   localparam logic [3:0] REG_FIFO = 4'h4;
   localparam logic [3:0] REG_LANE0 = 4'h5;
   localparam logic [3:0] REG_LANE1 = 4'h6;
   localparam logic [1:0] CTRL_RESET_REQ_BIT = 2'h0;
   localparam logic [1:0] CTRL_LINK_EN_BIT = 2'h1;
endpackage

//--- tlk_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tlk_if;
   import tlk_pkg::*;
   logic [PAY_W-1:0] lane_octet_payload;
   logic payload_valid_flag;
   logic link_accepting_flag;
   logic [LANES-1:0] tx_ready;
   logic [LANES-1:0] tx_analog_ready;
   logic tx_hard_rst;
   logic link_enable;
   logic [RCFG_AW-1:0] rcfg_address;
   logic [RCFG_DW-1:0] rcfg_writedata;
   logic [RCFG_DW-1:0] rcfg_readdata;
   logic rcfg_write;
   logic rcfg_read;
   logic rcfg_waitrequest;
   modport dev (input lane_octet_payload, payload_valid_flag, tx_hard_rst, link_enable,
      rcfg_address, rcfg_writedata, rcfg_write, rcfg_read,
      output link_accepting_flag, tx_ready, tx_analog_ready, rcfg_readdata, rcfg_waitrequest);
   modport ctl (output lane_octet_payload, payload_valid_flag, tx_hard_rst, link_enable,
      rcfg_address, rcfg_writedata, rcfg_write, rcfg_read,
      input link_accepting_flag, tx_ready, tx_analog_ready, rcfg_readdata, rcfg_waitrequest);
endinterface
`default_nettype wire

//--- tlk_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module tlk_fifo
   import tlk_pkg::*;
#(
   parameter int W = 64,
   parameter int D = 32
) (
   input wire logic CLK_SYS, // clock
   input wire logic RST, // sync reset
   input wire logic CE, // clock enable
   input wire logic [W-1:0] IN_DATA, // write data
   input wire logic IN_VALID, // write request
   output logic IN_READY, // not full
   output logic [W-1:0] OUT_DATA, // head word
   output logic OUT_VALID, // not empty
   input wire logic OUT_READY // pop
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } tlk_fifo_st_t;
   tlk_fifo_st_t s_r, s_nxt;
   logic [W-1:0] mem [D];
   logic push, pop;

   // honest flags straight from the occupancy count
   assign IN_READY = (s_r.cnt != (AW+1)'(D));
   assign OUT_VALID = (s_r.cnt != '0);
   assign OUT_DATA = mem[s_r.rp];
   assign push = IN_VALID && IN_READY;
   assign pop = OUT_VALID && OUT_READY;

   always_comb begin
      s_nxt = s_r;
      if (push) s_nxt.wp = s_r.wp + 1'b1;
      if (pop) s_nxt.rp = s_r.rp + 1'b1;
      s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   // storage has no reset; only pointers and count need a defined value
   always_ff @(posedge CLK_SYS) begin
      if (CE && push) mem[s_r.wp] <= IN_DATA;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) s_r <= '0;
      else if (CE) s_r <= s_nxt;
   end
endmodule // tlk_fifo
`default_nettype wire

//--- tlk_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - reconfiguration read data is byte wide
// - write, read, waitrequest one bit, shared port
// - master drives read/write as high strobes
// - one transmit-ready bit per lane
// - no reset change before analog ready
// - hard reset active high, spares analog section
// - 32 payload bits per lane per cycle
// - first octet in bits 31:24 of lane
// - lane 0 lowest word, lane 1 next
// - source drives single payload valid bit
// - sink never stalls, takes data while ready
// - ready asserted in user phase, zero latency
module tlk_dev
   import tlk_pkg::*;
(
   input wire logic CLK_SYS, // clock
   input wire logic RST, // sync reset
   input wire logic CE, // clock enable
   tlk_if.dev LNK, // link towards the controller
   output logic [PAY_W-1:0] SER_WORD, // word handed to serializer
   output logic SER_VALID, // serializer word valid
   output logic SER_LANE_ERR // consumed with valid low
);
   typedef struct packed {
      tlk_phase_t phase;
      logic [LANES-1:0] analog_rdy;
      logic [LANES-1:0] tx_rdy;
      logic [1:0] sync_cnt;
      logic [PAY_W-1:0] word;
      logic wvalid;
      logic err;
      logic [RCFG_DW-1:0] rdata;
      logic [3:0][RCFG_DW-1:0] cfg;
   } tlk_dev_st_t;
   tlk_dev_st_t s_r, s_nxt;

   assign LNK.tx_analog_ready = s_r.analog_rdy;
   assign LNK.tx_ready = s_r.tx_rdy;
   assign LNK.rcfg_readdata = s_r.rdata;
   assign LNK.rcfg_waitrequest = 1'b0;
   assign LNK.link_accepting_flag = (s_r.phase == TLK_USER);
   assign SER_WORD = s_r.word;
   assign SER_VALID = s_r.wvalid;
   assign SER_LANE_ERR = s_r.err;

   always_comb begin
      s_nxt = s_r;
      s_nxt.wvalid = 1'b0;
      // analog section comes up after core reset and is untouched by hard reset
      s_nxt.analog_rdy = '1;
      if (LNK.tx_hard_rst) begin
         s_nxt.tx_rdy = '0;
         s_nxt.phase = TLK_DOWN;
      end else begin
         s_nxt.tx_rdy = s_r.analog_rdy;
         case (s_r.phase)
            TLK_DOWN: begin
               s_nxt.sync_cnt = '0;
               if ((&s_r.tx_rdy) && LNK.link_enable) s_nxt.phase = TLK_SYNC;
            end
            TLK_SYNC: begin
               s_nxt.sync_cnt = s_r.sync_cnt + 2'h1;
               if (!LNK.link_enable) s_nxt.phase = TLK_DOWN;
               else if (&s_r.sync_cnt) s_nxt.phase = TLK_USER;
            end
            TLK_USER: begin
               // no backpressure: payload is taken every ready cycle
               s_nxt.word = LNK.lane_octet_payload;
               s_nxt.wvalid = 1'b1;
               if (!LNK.payload_valid_flag) s_nxt.err = 1'b1;
               if (!LNK.link_enable) s_nxt.phase = TLK_DOWN;
            end
            default: s_nxt.phase = TLK_DOWN;
         endcase
      end
      // small byte-wide reconfiguration space, answered in one cycle
      if (LNK.rcfg_write) s_nxt.cfg[LNK.rcfg_address[1:0]] = LNK.rcfg_writedata;
      if (LNK.rcfg_read) s_nxt.rdata = s_r.cfg[LNK.rcfg_address[1:0]];
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) s_r <= '0;
      else if (CE) s_r <= s_nxt;
   end
endmodule // tlk_dev
`default_nettype wire

//--- tlk_ctl.sv
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tlk_ctl
   import tlk_pkg::*;
(
   input wire logic CLK_SYS, // clock
   input wire logic RST, // sync reset
   input wire logic CE, // clock enable
   tlk_if.ctl LNK, // link towards the device
   input wire logic [3:0] ADDR, // register address
   input wire logic [31:0] WDATA, // write data
   input wire logic WR, // write strobe
   input wire logic RD, // read strobe
   output logic [31:0] RDATA // read data, cycle after RD
);
   typedef enum logic [1:0] {C_IDLE, C_WAIT, C_HOLD, C_RUN} tlk_cst_t;
   typedef struct packed {
      tlk_cst_t st;
      logic [2:0] hold;
      logic rst_out;
      logic en;
      logic [RCFG_AW-1:0] raddr;
      logic [31:0] rd;
      logic [LANES-1:0][LANE_W-1:0] lane;
      logic stage;
   } tlk_ctl_st_t;
   tlk_ctl_st_t s_r, s_nxt;
   logic f_in_ready, f_out_valid;
   logic [PAY_W-1:0] f_out, f_in;
   logic f_push;

   // lane k sits at bits 32k+31:32k, first octet highest
   genvar k;
   generate
      for (k = 0; k < LANES; k++) begin : g_lane
         assign f_in[k*LANE_W +: LANE_W] = s_r.lane[k];
      end
   endgenerate
   assign f_push = s_r.stage;

   // buffer drains only while the sink is accepting
   tlk_fifo #(.W(PAY_W), .D(FIFO_DEPTH)) u_fifo (
      .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE),
      .IN_DATA(f_in), .IN_VALID(f_push), .IN_READY(f_in_ready),
      .OUT_DATA(f_out), .OUT_VALID(f_out_valid), .OUT_READY(LNK.link_accepting_flag));

   assign LNK.tx_hard_rst = s_r.rst_out;
   assign LNK.link_enable = s_r.en;
   assign LNK.lane_octet_payload = f_out;
   // valid is honest; the sink assumes valid anyway, so keep the buffer primed
   assign LNK.payload_valid_flag = f_out_valid;
   assign LNK.rcfg_address = s_r.raddr;
   assign LNK.rcfg_writedata = WDATA[RCFG_DW-1:0];
   assign LNK.rcfg_write = WR && (ADDR == REG_RCFG_DATA);
   assign LNK.rcfg_read = RD && (ADDR == REG_RCFG_DATA);
   assign RDATA = s_r.rd;

   always_comb begin
      s_nxt = s_r;
      s_nxt.stage = 1'b0;
      case (s_r.st)
         C_IDLE: if (WR && ADDR == REG_CTRL && WDATA[CTRL_RESET_REQ_BIT]) s_nxt.st = C_WAIT;
         C_WAIT: begin
            // reset may change only once every lane's analog side is ready
            if (&LNK.tx_analog_ready) begin
               s_nxt.rst_out = 1'b1;
               s_nxt.hold = '0;
               s_nxt.st = C_HOLD;
            end
         end
         C_HOLD: begin
            s_nxt.hold = s_r.hold + 3'h1;
            if (s_r.hold == 3'(RST_HOLD_CYC - 1) && (&LNK.tx_analog_ready)) begin
               s_nxt.rst_out = 1'b0;
               s_nxt.st = C_RUN;
            end
         end
         C_RUN: if (WR && ADDR == REG_CTRL && WDATA[CTRL_RESET_REQ_BIT]) s_nxt.st = C_WAIT;
         default: s_nxt.st = C_IDLE;
      endcase
      if (WR) begin
         case (ADDR)
            REG_CTRL: s_nxt.en = WDATA[CTRL_LINK_EN_BIT];
            REG_RCFG_ADDR: s_nxt.raddr = WDATA[RCFG_AW-1:0];
            REG_LANE0: s_nxt.lane[0] = WDATA;
            REG_LANE1: begin
               s_nxt.lane[1] = WDATA;
               s_nxt.stage = f_in_ready; // lane 1 write commits the word
            end
            default: ;
         endcase
      end
      if (RD) begin
         case (ADDR)
            REG_CTRL: s_nxt.rd = {30'h0, s_r.en, s_r.rst_out};
            REG_STAT: s_nxt.rd = {24'h0, s_r.st, LNK.link_accepting_flag, 1'b0,
               LNK.tx_ready[1], LNK.tx_ready[0], LNK.tx_analog_ready[1], LNK.tx_analog_ready[0]};
            REG_RCFG_ADDR: s_nxt.rd = {21'h0, s_r.raddr};
            // slave answers a cycle late, so this returns the previous reconfig read
            REG_RCFG_DATA: s_nxt.rd = {24'h0, LNK.rcfg_readdata};
            REG_FIFO: s_nxt.rd = {30'h0, f_out_valid, f_in_ready};
            default: s_nxt.rd = 32'h0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) s_r <= '0;
      else if (CE) s_r <= s_nxt;
   end
endmodule // tlk_ctl
`default_nettype wire

//--- tlk_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tlk_link_sva
   import tlk_pkg::*;
(
   input wire logic CLK_SYS, // clock
   input wire logic RST, // sync reset
   input wire logic link_accepting_flag, // sink ready
   input wire logic link_enable, // link enable from controller
   input wire logic [LANES-1:0] tx_ready, // per-lane transmit ready
   input wire logic [LANES-1:0] tx_analog_ready, // per-lane analog ready
   input wire logic tx_hard_rst, // transmit hard reset
   input wire logic rcfg_write, // reconfig write strobe
   input wire logic rcfg_read, // reconfig read strobe
   input wire logic rcfg_waitrequest // reconfig wait
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // the slave never stalls, so the master has no wait loop to fall back on
   property p_nowait; !rcfg_waitrequest; endproperty
   a_nowait: assert property (p_nowait) else $error("reconfig wait raised");
   property p_strobe; !(rcfg_write && rcfg_read); endproperty
   a_strobe: assert property (p_strobe) else $error("reconfig read and write together");
   property p_rst_gate; $changed(tx_hard_rst) |-> &tx_analog_ready; endproperty
   a_rst_gate: assert property (p_rst_gate) else $error("hard reset moved before analog ready");
   property p_hold; $rose(tx_hard_rst) |-> tx_hard_rst [*4] ##1 !tx_hard_rst; endproperty
   a_hold: assert property (p_hold) else $error("hard reset pulse length wrong");
   property p_hard_drop; tx_hard_rst |=> !link_accepting_flag; endproperty
   a_hard_drop: assert property (p_hard_drop) else $error("sink ready during hard reset");
   property p_accept_ready; link_accepting_flag && !tx_hard_rst |-> &tx_ready; endproperty
   a_accept_ready: assert property (p_accept_ready) else $error("sink ready without lane ready");
   property p_ready_after; (tx_ready & ~tx_analog_ready) == '0; endproperty
   a_ready_after: assert property (p_ready_after) else $error("lane ready before analog ready");
   property p_sync; $rose(link_accepting_flag) |-> $past(link_enable, 3) && (&$past(tx_ready, 3)); endproperty
   a_sync: assert property (p_sync) else $error("user phase without sync phase");
   c_accept: cover property ($rose(link_accepting_flag));
   c_hard: cover property ($rose(tx_hard_rst));
   c_rcfg: cover property (rcfg_write);
endmodule // tlk_link_sva
`default_nettype wire

//--- tx_link_stream_and_phy_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
   $display("ERROR %s expected %h seen %h", n, e, s); end end
module tx_link_stream_and_phy_ports_tb
   import tlk_pkg::*;
;
   typedef struct {logic [3:0] a; logic [31:0] m; logic [31:0] e;} tlk_row_t;
   logic clk, rst, ce, wr, rd, ser_valid, ser_err;
   logic [3:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [PAY_W-1:0] ser_word;
   logic [7:0] rcfg_wd;
   int mismatches, checks_done, n, hr_cnt, rw_cnt;
   tlk_row_t rows [4] = '{'{REG_STAT, 32'h2f, 32'hf}, '{4'h7, 32'hffffffff, 32'h0},
      '{4'hf, 32'hffffffff, 32'h0}, '{REG_FIFO, 32'h3, 32'h1}};
   tlk_if u_tlk_if ();
   tlk_dev u_tlk_dev (.CLK_SYS(clk), .RST(rst), .CE(ce), .LNK(u_tlk_if), .SER_WORD(ser_word),
      .SER_VALID(ser_valid), .SER_LANE_ERR(ser_err));
   tlk_ctl u_tlk_ctl (.CLK_SYS(clk), .RST(rst), .CE(ce), .LNK(u_tlk_if), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata));
   tlk_link_sva u_tlk_link_sva (.CLK_SYS(clk), .RST(rst), .link_accepting_flag(u_tlk_if.link_accepting_flag),
      .link_enable(u_tlk_if.link_enable), .tx_ready(u_tlk_if.tx_ready),
      .tx_analog_ready(u_tlk_if.tx_analog_ready), .tx_hard_rst(u_tlk_if.tx_hard_rst),
      .rcfg_write(u_tlk_if.rcfg_write), .rcfg_read(u_tlk_if.rcfg_read),
      .rcfg_waitrequest(u_tlk_if.rcfg_waitrequest));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // interface monitors: counted here since a pulse may fall between bus tasks
   always @(posedge clk) begin
      if (u_tlk_if.tx_hard_rst === 1'b1) hr_cnt++;
      if (u_tlk_if.rcfg_write === 1'b1) begin
         rw_cnt++;
         rcfg_wd = u_tlk_if.rcfg_writedata;
      end
   end
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog at 3000 cycles, far beyond the roughly 80 cycles the tests need
   initial begin
      #75000;
      mismatches++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      hr_cnt = 0;
      rw_cnt = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      #1 `CHK("lane_err", 1'b0, ser_err)
      `CHK("hard_rst", 1'b0, u_tlk_if.tx_hard_rst)
      `CHK("payload_w", LANES * 32, $bits(u_tlk_if.lane_octet_payload))
      `CHK("rcfg_dw", 8, $bits(u_tlk_if.rcfg_readdata))
      `CHK("strobe_w", 1, $bits(u_tlk_if.rcfg_write) + $bits(u_tlk_if.rcfg_read) - 1)
      $display("test reset done");
      foreach (rows[i]) begin
         bus_rd(rows[i].a, d);
         `CHK("reg", rows[i].e, d & rows[i].m)
      end
      $display("test registers done");
      // two words queued before the link opens, so they leave back to back
      bus_wr(REG_LANE0, 32'h00112233);
      bus_wr(REG_LANE1, 32'h44556677);
      bus_wr(REG_LANE0, 32'h8899aabb);
      bus_wr(REG_LANE1, 32'hccddeeff);
      bus_wr(REG_CTRL, 32'h2);
      n = 0;
      while (u_tlk_if.link_accepting_flag !== 1'b1 && n < 50) begin
         @(posedge clk);
         #1 n++;
      end
      `CHK("link_up", 1'b1, u_tlk_if.link_accepting_flag)
      `CHK("valid", 1'b1, u_tlk_if.payload_valid_flag)
      `CHK("lane1_first", 8'h44, u_tlk_if.lane_octet_payload[63:56])
      `CHK("lane0_first", 8'h00, u_tlk_if.lane_octet_payload[31:24])
      `CHK("lane0_last", 8'h33, u_tlk_if.lane_octet_payload[7:0])
      @(posedge clk);
      #1 `CHK("ser_valid", 1'b1, ser_valid)
      `CHK("word0", 64'h44556677_00112233, ser_word)
      @(posedge clk);
      #1 `CHK("word1", 64'hccddeeff_8899aabb, ser_word)
      repeat (3) @(posedge clk);
      #1 `CHK("lane_err", 1'b1, ser_err)
      bus_rd(REG_STAT, d);
      `CHK("stat_accept", 1'b1, d[5])
      $display("test stream done");
      // request is a one-shot write; the follow-up write keeps link enable set with the request bit clear
      bus_wr(REG_CTRL, 32'h3);
      bus_wr(REG_CTRL, 32'h2);
      repeat (20) @(posedge clk);
      #1 `CHK("hold", RST_HOLD_CYC, hr_cnt)
      `CHK("analog", 2'h3, u_tlk_if.tx_analog_ready)
      `CHK("relink", 1'b1, u_tlk_if.link_accepting_flag)
      $display("test hard reset done");
      bus_wr(REG_RCFG_ADDR, 32'h5);
      bus_wr(REG_RCFG_DATA, 32'h5a);
      repeat (2) @(posedge clk);
      #1 `CHK("rcfg_writes", 1, rw_cnt)
      `CHK("rcfg_data", 8'h5a, rcfg_wd)
      // the slave answers a cycle late, so the second read returns the first one's byte
      bus_rd(REG_RCFG_DATA, d);
      bus_rd(REG_RCFG_DATA, d);
      `CHK("rcfg_rd", 8'h5a, d[7:0])
      $display("test reconfig done");
      // clock enable low: a register write in that window must be lost
      @(posedge clk);
      ce <= 1'b0;
      bus_wr(REG_RCFG_ADDR, 32'h7);
      ce <= 1'b1;
      bus_rd(REG_RCFG_ADDR, d);
      `CHK("ce_freeze", 32'h5, d)
      $display("test clock enable done");
      // reset in mid-run drops the link and the lane flags at once
      @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      #1 `CHK("rst_accept", 1'b0, u_tlk_if.link_accepting_flag)
      `CHK("rst_txrdy", 2'h0, u_tlk_if.tx_ready)
      `CHK("rst_hard", 1'b0, u_tlk_if.tx_hard_rst)
      @(posedge clk);
      #1 `CHK("rst_analog", 2'h3, u_tlk_if.tx_analog_ready)
      `CHK("rst_txrdy_lag", 2'h0, u_tlk_if.tx_ready)
      $display("test mid-run reset done");
      end_of_test();
   end
endmodule // tx_link_stream_and_phy_ports_tb
`default_nettype wire
